// File: rtl/gsi_pkg.sv
// How it works
// - Opcode 0x91 selects the geometry setup command.
// - Geometry: busy, store, release busy, interrupt.
// - Host loads count and head nibble first.
// - Zero sector count aborts the geometry command.
// - Stored geometry survives soft resets; power-on reset restores defaults.
// - Geometry ignores the logical addressing bit.
// - Logical addressing stays within the default area.
// - Host takes total sectors from words 60-61.
// - Opcode 0xEC returns a 512 byte page.
// - Identify: busy, fill buffer, data request, interrupt.
// - Host reads the whole page through data.
// - Word 6 reports 63 sectors per track.
// - Word 21 is 0x0400, word 22 0x0004.
// - Word 47 holds 0x8010.
// - Words 54-58 report current geometry and total.
// - Words 60-61 total, word 59 multiple count.
// - Word 49 is 0x0B00, word 53 0x0007.
// - Word 63 low byte 0x07, word 64 0x0003.
// - Words 65-68 each report 0x0078.
// - Words 80, 82, 83 give versions and sets.
// - Words 84 and 87 read 0x4000.
// - Word 93 top nibble shows cable detection.
package gsi_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int PAGE_WORDS = 256;
  localparam int IDX_W = 8;
  localparam int FIFO_DEPTH = 8;

  localparam logic [9:0] OFF_DATA      = 10'h1f0;
  localparam logic [9:0] OFF_FEATURE   = 10'h1f1;
  localparam logic [9:0] OFF_COUNT     = 10'h1f2;
  localparam logic [9:0] OFF_SECTOR    = 10'h1f3;
  localparam logic [9:0] OFF_CYL_LO    = 10'h1f4;
  localparam logic [9:0] OFF_CYL_HI    = 10'h1f5;
  localparam logic [9:0] OFF_UNIT_HEAD = 10'h1f6;
  localparam logic [9:0] OFF_OPCODE    = 10'h1f7;

  localparam logic [7:0] OPC_GEOMETRY = 8'h91;
  localparam logic [7:0] OPC_IDENTIFY = 8'hec;

  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int UH_HEAD_HI = 3;

  localparam logic [7:0] DEF_SPT      = 8'h3f;
  localparam logic [3:0] DEF_MAX_HEAD = 4'hf;

  localparam logic [7:0] W_GENCFG  = 8'h00;
  localparam logic [7:0] W_CYLS    = 8'h01;
  localparam logic [7:0] W_HEADS   = 8'h03;
  localparam logic [7:0] W_SPT     = 8'h06;
  localparam logic [7:0] W_SER_LO  = 8'h0a;
  localparam logic [7:0] W_SER_HI  = 8'h13;
  localparam logic [7:0] W_BUFSZ   = 8'h15;
  localparam logic [7:0] W_ECC     = 8'h16;
  localparam logic [7:0] W_TXT_LO  = 8'h17;
  localparam logic [7:0] W_TXT_HI  = 8'h2e;
  localparam logic [7:0] W_MULTMAX = 8'h2f;
  localparam logic [7:0] W_CAPS    = 8'h31;
  localparam logic [7:0] W_PIO     = 8'h33;
  localparam logic [7:0] W_VALID   = 8'h35;
  localparam logic [7:0] W_CUR_CYL = 8'h36;
  localparam logic [7:0] W_CUR_HD  = 8'h37;
  localparam logic [7:0] W_CUR_SPT = 8'h38;
  localparam logic [7:0] W_CUR_TLO = 8'h39;
  localparam logic [7:0] W_CUR_THI = 8'h3a;
  localparam logic [7:0] W_MULTCUR = 8'h3b;
  localparam logic [7:0] W_LBA_LO  = 8'h3c;
  localparam logic [7:0] W_LBA_HI  = 8'h3d;
  localparam logic [7:0] W_MWDMA   = 8'h3f;
  localparam logic [7:0] W_ADVPIO  = 8'h40;
  localparam logic [7:0] W_CYC_LO  = 8'h41;
  localparam logic [7:0] W_CYC_HI  = 8'h44;
  localparam logic [7:0] W_MAJOR   = 8'h50;
  localparam logic [7:0] W_SETS1   = 8'h52;
  localparam logic [7:0] W_SETS2   = 8'h53;
  localparam logic [7:0] W_EXT     = 8'h54;
  localparam logic [7:0] W_DEFSET  = 8'h57;
  localparam logic [7:0] W_UDMA    = 8'h58;
  localparam logic [7:0] W_CABLE   = 8'h5d;

  localparam logic [15:0] V_GENCFG  = 16'h045a;
  localparam logic [15:0] V_SPT     = 16'h003f;
  localparam logic [15:0] V_TEXT    = 16'h2020;
  localparam logic [15:0] V_BUFSZ   = 16'h0400;
  localparam logic [15:0] V_ECC     = 16'h0004;
  localparam logic [15:0] V_MULTMAX = 16'h8010;
  localparam logic [15:0] V_CAPS    = 16'h0b00;
  localparam logic [15:0] V_PIO     = 16'h0200;
  localparam logic [15:0] V_VALID   = 16'h0007;
  localparam logic [15:0] V_MWDMA   = 16'h0007;
  localparam logic [15:0] V_ADVPIO  = 16'h0003;
  localparam logic [15:0] V_CYCLE   = 16'h0078;
  localparam logic [15:0] V_MAJOR   = 16'h001e;
  localparam logic [15:0] V_SETS1   = 16'h346b;
  localparam logic [15:0] V_SETS2   = 16'h4008;
  localparam logic [15:0] V_FIXED   = 16'h4000;
  localparam logic [15:0] V_UDMA    = 16'h001f;
  localparam logic [15:0] V_ZERO    = 16'h0000;
  localparam int CABLE_BIT = 13;

  typedef enum {DEV_IDLE, DEV_GEOM, DEV_FILL, DEV_XFER} gsi_dev_state_type;
  typedef enum {HST_IDLE, HST_W_COUNT, HST_W_HEAD, HST_W_CMD, HST_WAIT_IRQ,
                HST_WAIT_ST, HST_RD_DATA, HST_WAIT_DATA, HST_DONE}
    gsi_host_state_type;
endpackage

// File: rtl/gsi_if.sv
`timescale 1ns/1ns
interface gsi_if;
  logic [9:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        rack;
  logic        intrq;
  modport dev  (input addr, wdata, wr, rd, output rdata, rack, intrq);
  modport host (output addr, wdata, wr, rd, input rdata, rack, intrq);
endinterface

// File: rtl/gsi_fifo.sv
`timescale 1ns/1ns
module gsi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Full is compared at the counter's width, where DEPTH still fits.
  assign in_ready  = count != (PW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// File: rtl/gsi_device.sv
`timescale 1ns/1ns
module gsi_device #(
  parameter logic [15:0] CYLINDERS   = 16'h3fff,
  parameter logic [15:0] HEADS       = 16'h0010,
  parameter logic [31:0] LBA_TOTAL   = 32'h00ff_ffff,
  parameter logic [15:0] MULT_SET    = 16'h0000,
  parameter int          FIFO_DEPTH  = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic por_n,
  input  wire logic cable_detect,
  gsi_if.dev        bus,
  output logic [7:0] geom_spt,
  output logic [3:0] geom_max_head
);
  gsi_pkg::gsi_dev_state_type state;
  logic [7:0]  fault_info;
  logic [7:0]  sector_count;
  logic [7:0]  sector_index;
  logic [7:0]  cyl_low_byte;
  logic [7:0]  cyl_high_byte;
  logic [7:0]  unit_head_select;
  logic        err;
  logic        drq;
  logic        intrq;
  logic [15:0] rdata;
  logic        rack;
  logic [7:0]  fill_idx;
  logic [8:0]  feed_idx;
  logic [8:0]  pop_cnt;
  logic [15:0] page_val;
  logic [15:0] sector_buf [gsi_pkg::PAGE_WORDS];
  logic [15:0] fifo_out;
  logic        fifo_in_ready;
  logic        fifo_out_valid;

  wire busy     = state != gsi_pkg::DEV_IDLE && state != gsi_pkg::DEV_XFER;
  wire wr_ok    = bus.wr && !busy && !drq;
  wire wr_count = wr_ok && bus.addr == gsi_pkg::OFF_COUNT;
  wire wr_opc   = wr_ok && bus.addr == gsi_pkg::OFF_OPCODE;
  wire is_geom  = bus.wdata[7:0] == gsi_pkg::OPC_GEOMETRY;
  wire is_ident = bus.wdata[7:0] == gsi_pkg::OPC_IDENTIFY;
  wire rd_data  = bus.rd && bus.addr == gsi_pkg::OFF_DATA;
  wire rd_stat  = bus.rd && bus.addr == gsi_pkg::OFF_OPCODE;
  wire feed_end = feed_idx == 9'(gsi_pkg::PAGE_WORDS);
  wire fill_end = fill_idx == 8'(gsi_pkg::PAGE_WORDS - 1);
  wire pop      = rd_data && drq && fifo_out_valid;
  wire last_pop = pop && pop_cnt == 9'(gsi_pkg::PAGE_WORDS - 1);
  wire set_irq  = state == gsi_pkg::DEV_GEOM
               || (state == gsi_pkg::DEV_FILL && fill_end);
  wire [7:0] status = {busy, 1'b1, 1'b0, 1'b1, drq, 3'b000}
                    | {7'h00, err};
  // Current total follows the stored geometry; the logical total does not.
  wire [31:0] cur_total = 32'(CYLINDERS) * (32'(geom_max_head) + 32'h1)
                        * 32'(geom_spt);

  gsi_fifo #(
    .WIDTH (gsi_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) i_gsi_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (drq && !feed_end),
    .in_ready  (fifo_in_ready),
    .in_data   (sector_buf[feed_idx[7:0]]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out)
  );

  always_comb
  begin
    page_val = gsi_pkg::V_ZERO;
    case (fill_idx) inside
      gsi_pkg::W_GENCFG:  page_val = gsi_pkg::V_GENCFG;
      gsi_pkg::W_CYLS:    page_val = CYLINDERS;
      gsi_pkg::W_HEADS:   page_val = HEADS;
      gsi_pkg::W_SPT:     page_val = gsi_pkg::V_SPT;
      [gsi_pkg::W_SER_LO:gsi_pkg::W_SER_HI]: page_val = gsi_pkg::V_TEXT;
      gsi_pkg::W_BUFSZ:   page_val = gsi_pkg::V_BUFSZ;
      gsi_pkg::W_ECC:     page_val = gsi_pkg::V_ECC;
      [gsi_pkg::W_TXT_LO:gsi_pkg::W_TXT_HI]: page_val = gsi_pkg::V_TEXT;
      gsi_pkg::W_MULTMAX: page_val = gsi_pkg::V_MULTMAX;
      gsi_pkg::W_CAPS:    page_val = gsi_pkg::V_CAPS;
      gsi_pkg::W_PIO:     page_val = gsi_pkg::V_PIO;
      gsi_pkg::W_VALID:   page_val = gsi_pkg::V_VALID;
      gsi_pkg::W_CUR_CYL: page_val = CYLINDERS;
      gsi_pkg::W_CUR_HD:  page_val = 16'(geom_max_head) + 16'h0001;
      gsi_pkg::W_CUR_SPT: page_val = 16'(geom_spt);
      gsi_pkg::W_CUR_TLO: page_val = cur_total[15:0];
      gsi_pkg::W_CUR_THI: page_val = cur_total[31:16];
      gsi_pkg::W_MULTCUR: page_val = MULT_SET;
      gsi_pkg::W_LBA_LO:  page_val = LBA_TOTAL[15:0];
      gsi_pkg::W_LBA_HI:  page_val = LBA_TOTAL[31:16];
      gsi_pkg::W_MWDMA:   page_val = gsi_pkg::V_MWDMA;
      gsi_pkg::W_ADVPIO:  page_val = gsi_pkg::V_ADVPIO;
      [gsi_pkg::W_CYC_LO:gsi_pkg::W_CYC_HI]: page_val = gsi_pkg::V_CYCLE;
      gsi_pkg::W_MAJOR:   page_val = gsi_pkg::V_MAJOR;
      gsi_pkg::W_SETS1:   page_val = gsi_pkg::V_SETS1;
      gsi_pkg::W_SETS2:   page_val = gsi_pkg::V_SETS2;
      gsi_pkg::W_EXT:     page_val = gsi_pkg::V_FIXED;
      gsi_pkg::W_DEFSET:  page_val = gsi_pkg::V_FIXED;
      gsi_pkg::W_UDMA:    page_val = gsi_pkg::V_UDMA;
      gsi_pkg::W_CABLE:   page_val = 16'(cable_detect) << gsi_pkg::CABLE_BIT;
      default:            page_val = gsi_pkg::V_ZERO;
    endcase
  end

  // Geometry sits on the power-on reset only, so a host or soft reset
  // leaves the translation in place.
  always_ff @(posedge clk)
  begin
    if (!por_n)
    begin
      geom_spt      <= gsi_pkg::DEF_SPT;
      geom_max_head <= gsi_pkg::DEF_MAX_HEAD;
    end
    else if (state == gsi_pkg::DEV_GEOM && sector_count != gsi_pkg::BYTE_ZERO)
    begin
      geom_spt      <= sector_count;
      geom_max_head <= unit_head_select[gsi_pkg::UH_HEAD_HI:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sector_count     <= gsi_pkg::BYTE_ZERO;
      sector_index     <= gsi_pkg::BYTE_ZERO;
      cyl_low_byte     <= gsi_pkg::BYTE_ZERO;
      cyl_high_byte    <= gsi_pkg::BYTE_ZERO;
      unit_head_select <= gsi_pkg::BYTE_ZERO;
    end
    else if (wr_ok)
    begin
      if (wr_count)
        sector_count <= bus.wdata[7:0];
      if (bus.addr == gsi_pkg::OFF_SECTOR)
        sector_index <= bus.wdata[7:0];
      if (bus.addr == gsi_pkg::OFF_CYL_LO)
        cyl_low_byte <= bus.wdata[7:0];
      if (bus.addr == gsi_pkg::OFF_CYL_HI)
        cyl_high_byte <= bus.wdata[7:0];
      if (bus.addr == gsi_pkg::OFF_UNIT_HEAD)
        unit_head_select <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state      <= gsi_pkg::DEV_IDLE;
      err        <= 1'b0;
      fault_info <= gsi_pkg::BYTE_ZERO;
      drq        <= 1'b0;
      fill_idx   <= '0;
      pop_cnt    <= '0;
    end
    else
    begin
      case (state)
        gsi_pkg::DEV_IDLE:
          if (wr_opc)
          begin
            err        <= !is_geom && !is_ident;
            fault_info <= (is_geom || is_ident) ? gsi_pkg::BYTE_ZERO
                                                : gsi_pkg::ERR_ABORT;
            fill_idx   <= '0;
            if (is_geom)
              state <= gsi_pkg::DEV_GEOM;
            else if (is_ident)
              state <= gsi_pkg::DEV_FILL;
          end
        gsi_pkg::DEV_GEOM:
        begin
          // Logical addressing never sees these values.
          if (sector_count == gsi_pkg::BYTE_ZERO)
          begin
            err        <= 1'b1;
            fault_info <= gsi_pkg::ERR_ABORT;
          end
          state <= gsi_pkg::DEV_IDLE;
        end
        gsi_pkg::DEV_FILL:
        begin
          sector_buf[fill_idx] <= page_val;
          fill_idx <= fill_idx + 1'b1;
          if (fill_end)
          begin
            drq     <= 1'b1;
            pop_cnt <= '0;
            state   <= gsi_pkg::DEV_XFER;
          end
        end
        gsi_pkg::DEV_XFER:
        begin
          if (pop)
            pop_cnt <= pop_cnt + 1'b1;
          if (last_pop)
          begin
            drq   <= 1'b0;
            state <= gsi_pkg::DEV_IDLE;
          end
        end
        default: state <= gsi_pkg::DEV_IDLE;
      endcase
    end
  end

  // The feeder walks the buffer in order; a full FIFO stalls it.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !drq)
      feed_idx <= '0;
    else if (fifo_in_ready && !feed_end)
      feed_idx <= feed_idx + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      intrq <= 1'b0;
      rack  <= 1'b0;
      rdata <= gsi_pkg::V_ZERO;
    end
    else
    begin
      rack <= bus.rd;
      if (set_irq)
        intrq <= 1'b1;
      else if (rd_stat || wr_opc)
        intrq <= 1'b0;
      if (rd_data)
        rdata <= pop ? fifo_out : gsi_pkg::V_ZERO;
      else if (rd_stat)
        rdata <= {8'h00, status};
      else if (bus.addr == gsi_pkg::OFF_FEATURE)
        rdata <= {8'h00, fault_info};
      else if (bus.addr == gsi_pkg::OFF_COUNT)
        rdata <= {8'h00, sector_count};
      else if (bus.addr == gsi_pkg::OFF_SECTOR)
        rdata <= {8'h00, sector_index};
      else if (bus.addr == gsi_pkg::OFF_CYL_LO)
        rdata <= {8'h00, cyl_low_byte};
      else if (bus.addr == gsi_pkg::OFF_CYL_HI)
        rdata <= {8'h00, cyl_high_byte};
      else if (bus.addr == gsi_pkg::OFF_UNIT_HEAD)
        rdata <= {8'h00, unit_head_select};
      else
        rdata <= gsi_pkg::V_ZERO;
    end
  end

  assign bus.rdata = rdata;
  assign bus.rack  = rack;
  assign bus.intrq = intrq;
endmodule

// File: rtl/gsi_host.sv
`timescale 1ns/1ns
module gsi_host (
  input  wire logic  clk,
  input  wire logic  rst_n,
  gsi_if.host        bus,
  input  wire logic  start,
  input  wire logic  op_identify,
  input  wire logic [7:0] spt,
  input  wire logic [3:0] max_head,
  output logic       busy,
  output logic       done,
  output logic       error,
  output logic       word_valid,
  output logic [15:0] word_data,
  output logic [7:0] word_index,
  output logic [31:0] lba_total
);
  gsi_pkg::gsi_host_state_type state;
  logic [9:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic        ident;
  logic [7:0]  idx;
  wire         last = idx == 8'(gsi_pkg::PAGE_WORDS - 1);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state      <= gsi_pkg::HST_IDLE;
      addr       <= gsi_pkg::OFF_DATA;
      wdata      <= gsi_pkg::V_ZERO;
      wr         <= 1'b0;
      rd         <= 1'b0;
      ident      <= 1'b0;
      idx        <= '0;
      busy       <= 1'b0;
      done       <= 1'b0;
      error      <= 1'b0;
      word_valid <= 1'b0;
      word_data  <= gsi_pkg::V_ZERO;
      word_index <= '0;
      lba_total  <= '0;
    end
    else
    begin
      wr         <= 1'b0;
      rd         <= 1'b0;
      done       <= 1'b0;
      word_valid <= 1'b0;
      case (state)
        gsi_pkg::HST_IDLE:
          if (start)
          begin
            ident <= op_identify;
            busy  <= 1'b1;
            idx   <= '0;
            state <= op_identify ? gsi_pkg::HST_W_CMD : gsi_pkg::HST_W_COUNT;
          end
        gsi_pkg::HST_W_COUNT:
        begin
          addr  <= gsi_pkg::OFF_COUNT;
          wdata <= {8'h00, spt};
          wr    <= 1'b1;
          state <= gsi_pkg::HST_W_HEAD;
        end
        gsi_pkg::HST_W_HEAD:
        begin
          addr  <= gsi_pkg::OFF_UNIT_HEAD;
          wdata <= {12'h000, max_head};
          wr    <= 1'b1;
          state <= gsi_pkg::HST_W_CMD;
        end
        gsi_pkg::HST_W_CMD:
        begin
          addr  <= gsi_pkg::OFF_OPCODE;
          wdata <= {8'h00, ident ? gsi_pkg::OPC_IDENTIFY
                                 : gsi_pkg::OPC_GEOMETRY};
          wr    <= 1'b1;
          state <= gsi_pkg::HST_WAIT_IRQ;
        end
        gsi_pkg::HST_WAIT_IRQ:
          if (bus.intrq && !wr)
          begin
            addr  <= gsi_pkg::OFF_OPCODE;
            rd    <= 1'b1;
            state <= gsi_pkg::HST_WAIT_ST;
          end
        gsi_pkg::HST_WAIT_ST:
          if (bus.rack)
          begin
            error <= bus.rdata[gsi_pkg::ST_ERR];
            state <= bus.rdata[gsi_pkg::ST_DRQ] ? gsi_pkg::HST_RD_DATA
                                                : gsi_pkg::HST_DONE;
          end
        gsi_pkg::HST_RD_DATA:
        begin
          addr  <= gsi_pkg::OFF_DATA;
          rd    <= 1'b1;
          state <= gsi_pkg::HST_WAIT_DATA;
        end
        gsi_pkg::HST_WAIT_DATA:
          if (bus.rack)
          begin
            word_valid <= 1'b1;
            word_data  <= bus.rdata;
            word_index <= idx;
            if (idx == gsi_pkg::W_LBA_LO)
              lba_total[15:0] <= bus.rdata;
            if (idx == gsi_pkg::W_LBA_HI)
              lba_total[31:16] <= bus.rdata;
            idx   <= idx + 1'b1;
            state <= last ? gsi_pkg::HST_DONE : gsi_pkg::HST_RD_DATA;
          end
        gsi_pkg::HST_DONE:
        begin
          busy  <= 1'b0;
          done  <= 1'b1;
          state <= gsi_pkg::HST_IDLE;
        end
        default: state <= gsi_pkg::HST_IDLE;
      endcase
    end
  end

  assign bus.addr  = addr;
  assign bus.wdata = wdata;
  assign bus.wr    = wr;
  assign bus.rd    = rd;
endmodule

// File: test/gsi_chk.sv
`timescale 1ns/1ns
module gsi_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [9:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        rack,
  input wire logic        intrq
);
  logic [9:0] last_addr;
  logic [8:0] widx;
  wire logic  op_wr = wr && addr == gsi_pkg::OFF_OPCODE;
  wire logic  gwr   = op_wr && wdata[7:0] == gsi_pkg::OPC_GEOMETRY;
  wire logic  iwr   = op_wr && wdata[7:0] == gsi_pkg::OPC_IDENTIFY;
  wire logic  dack  = rack && last_addr == gsi_pkg::OFF_DATA;

  // The read address is kept so an answer can be told apart from a status one.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      last_addr <= 10'h000;
      widx      <= 9'h000;
    end
    else
    begin
      if (rd)
        last_addr <= addr;
      if (iwr)
        widx <= 9'h000;
      else if (dack)
        widx <= widx + 9'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  rack_lat_a:
    assert property (rd |=> rack) else $error("read not answered");
  rack_cause_a:
    assert property (rack |-> $past(rd)) else $error("answer without read");
  geom_irq_a:
    assert property (gwr |=> !intrq ##[1:2] intrq)
      else $error("geometry interrupt wrong");
  ident_irq_a:
    assert property (iwr |=> (!intrq) [*8] ##[240:260] intrq)
      else $error("identify interrupt wrong");
  stat_clr_a:
    assert property (rd && addr == gsi_pkg::OFF_OPCODE |=> !intrq)
      else $error("status read left interrupt up");
  head_first_a:
    assert property (gwr |-> $past(wr)
      && $past(addr) == gsi_pkg::OFF_UNIT_HEAD)
      else $error("head not written before command");
  page_len_a:
    assert property (dack |-> widx < 9'h100) else $error("page too long");
  w_spt_a:
    assert property (dack && widx == 9'h006 |-> rdata == 16'h003f)
      else $error("word 6 wrong");
  w_caps_a:
    assert property (dack && widx == 9'h031 |-> rdata == 16'h0b00)
      else $error("word 49 wrong");
  w_fixed_a:
    assert property (dack && (widx == 9'h054 || widx == 9'h057)
      |-> rdata == 16'h4000) else $error("word 84 or 87 wrong");
endmodule

// File: test/geometry_setup_and_identify_cmds_tb.sv
`timescale 1ns/1ns
module geometry_setup_and_identify_cmds_tb;
  localparam logic [15:0] CYL  = 16'h0123;
  localparam logic [15:0] HDS  = 16'h0006;
  localparam logic [31:0] LBA  = 32'h0001_2345;
  localparam logic [15:0] MULT = 16'h0110;
  localparam logic [7:0]  FX_IDX [16] = '{8'h06, 8'h15, 8'h16, 8'h2f,
    8'h31, 8'h35, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h50, 8'h52, 8'h53,
    8'h54, 8'h57};
  localparam logic [15:0] FX_VAL [16] = '{16'h003f, 16'h0400, 16'h0004,
    16'h8010, 16'h0b00, 16'h0007, 16'h0003, 16'h0078, 16'h0078, 16'h0078,
    16'h0078, 16'h001e, 16'h346b, 16'h4008, 16'h4000, 16'h4000};
  logic        clk, rst_n, por_n, cable_detect, start, op_identify;
  logic [7:0]  spt, geom_spt, word_index;
  logic [3:0]  max_head, geom_max_head;
  logic        busy, done, error, word_valid;
  logic [15:0] word_data;
  logic [31:0] lba_total;
  logic [15:0] pg [256];
  int          num_errors, total_checks, cyc, nw;

  gsi_if bus_if();
  gsi_device #(.CYLINDERS(CYL), .HEADS(HDS), .LBA_TOTAL(LBA),
    .MULT_SET(MULT), .FIFO_DEPTH(gsi_pkg::FIFO_DEPTH)) i_gsi_device (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .cable_detect(cable_detect),
    .bus(bus_if), .geom_spt(geom_spt), .geom_max_head(geom_max_head));
  gsi_host i_gsi_host (.clk(clk), .rst_n(rst_n), .bus(bus_if),
    .start(start), .op_identify(op_identify), .spt(spt),
    .max_head(max_head), .busy(busy), .done(done), .error(error),
    .word_valid(word_valid), .word_data(word_data),
    .word_index(word_index), .lba_total(lba_total));
  gsi_chk i_gsi_chk (.clk(clk), .rst_n(rst_n), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
    .rdata(bus_if.rdata), .rack(bus_if.rack), .intrq(bus_if.intrq));

  always #20 clk = ~clk;

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Words are captured mid-cycle, where the host's flops have settled.
  always @(negedge clk)
  begin
    cyc++;
    if (word_valid === 1'b1)
    begin
      chk("word_index", nw, 32'(word_index));
      pg[nw[7:0]] = word_data;
      nw++;
    end
    if (cyc == 6000)
    begin
      num_errors++;
      tally_and_finish;
    end
  end

  task automatic run(input logic id, input logic [7:0] s, input logic [3:0] h);
    int n;
    @(negedge clk);
    op_identify = id;
    spt = s;
    max_head = h;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("busy", 32'h1, 32'(busy));
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk("done", 32'h1, 32'(done));
    chk("busy idle", 32'h0, 32'(busy));
  endtask

  task automatic t_geom(input logic [7:0] s, input logic [3:0] h,
                        input logic e, input logic [7:0] es,
                        input logic [3:0] eh);
    run(1'b0, s, h);
    chk("error", 32'(e), 32'(error));
    chk("geom_spt", 32'(es), 32'(geom_spt));
    chk("geom_max_head", 32'(eh), 32'(geom_max_head));
  endtask

  task automatic t_soft_reset;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("kept spt", 32'h11, 32'(geom_spt));
    chk("kept head", 32'h5, 32'(geom_max_head));
  endtask

  task automatic t_identify(input logic cab, input logic [7:0] s,
                            input logic [3:0] h);
    int i;
    logic [31:0] tot;
    tot = 32'(CYL) * (32'(h) + 32'h1) * 32'(s);
    cable_detect = cab;
    nw = 0;
    run(1'b1, 8'h00, 4'h0);
    chk("count", 9'h100, nw);
    chk("error", 32'h0, 32'(error));
    for (i = 0; i < 16; i++)
      chk("fixed", FX_VAL[i], pg[FX_IDX[i]]);
    chk("w54", CYL, pg[8'h36]);
    chk("w55", 32'(h) + 32'h1, pg[8'h37]);
    chk("w56", 32'(s), pg[8'h38]);
    chk("w57", tot, {pg[8'h3a], pg[8'h39]});
    chk("w59", MULT, pg[8'h3b]);
    chk("w60", LBA, {pg[8'h3d], pg[8'h3c]});
    chk("lba_total", LBA, lba_total);
    chk("w63", 8'h07, pg[8'h3f][7:0]);
    chk("w93", {2'b00, cab, 13'h0000}, pg[8'h5d]);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    por_n = 1'b0;
    cable_detect = 1'b0;
    start = 1'b0;
    op_identify = 1'b0;
    spt = 8'h00;
    max_head = 4'h0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    chk("default spt", 32'h3f, 32'(geom_spt));
    chk("default head", 32'hf, 32'(geom_max_head));
    t_identify(1'b1, 8'h3f, 4'hf);
    t_geom(8'h11, 4'h5, 1'b0, 8'h11, 4'h5);
    t_geom(8'h00, 4'h2, 1'b1, 8'h11, 4'h5);
    t_soft_reset();
    t_identify(1'b0, 8'h11, 4'h5);
    tally_and_finish;
  end
endmodule
